// ---- src/ksd_pkg.sv ----
/*
  Constants, register map and field layout for the kernel segment decoder
  and translation buffer register block.
  Assumes an AHB-Lite master with 32-bit single word transfers.
*/
package ksd_pkg;
  localparam logic [2:0] IDX_ENTRY_PTR  = 3'h0;
  localparam logic [2:0] IDX_REPLACE    = 3'h1;
  localparam logic [2:0] IDX_LOW_EVEN   = 3'h2;
  localparam logic [2:0] IDX_LOW_ODD    = 3'h3;
  localparam logic [2:0] IDX_PAGE_MASK  = 3'h5;
  localparam logic [2:0] IDX_WIRED      = 3'h6;
  localparam logic [2:0] IDX_CONTROL    = 3'h7;
  localparam int         PROBE_BIT      = 31;
  localparam int         MASK_LO        = 11;
  localparam int         MASK_HI        = 18;
  localparam int         ATTR_LO        = 3;
  localparam logic [4:0] REPLACE_TOP    = 5'h1F;
  localparam logic [4:0] WIRED_RESET    = 5'h00;
  localparam logic [2:0] UNCACHED_CODE  = 3'h2;
  localparam logic [31:0] LOW_KERNEL_BASE = 32'h8000_0000;
  localparam logic [31:0] UPPER_KERNEL_BASE = 32'hA000_0000;
  localparam logic [2:0] PHYS_CACHED_MIN = 3'h3;
  localparam logic [1:0] TOP_KERNEL     = 2'h3;
  localparam logic [1:0] TOP_PHYS       = 2'h2;
  typedef enum logic [3:0] {
    KSD_SEG_NONE, KSD_SEG_PHYS, KSD_SEG_KMAPPED, KSD_SEG_COMPAT0,
    KSD_SEG_COMPAT1, KSD_SEG_COMPATS, KSD_SEG_COMPAT3
  } ksd_seg_t;
  typedef enum logic [1:0] {
    KSD_OP_PROBE, KSD_OP_READ, KSD_OP_WRITE_IDX, KSD_OP_WRITE_RND
  } ksd_op_t;
endpackage : ksd_pkg

// ---- src/ksd_kernel_seg.sv ----
/*
  Kernel address decode plus translation buffer software registers.
  Assumes one AHB-Lite master; the TLB array lives outside and answers
  probes and reads through the tlb* ports in the same cycle as the op.
*/
// The AHB-Lite register port was left to the implementer.
`timescale 1ns/10ps
module ksd_kernel_seg
  import ksd_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic [63:0] vaddr,
  input  wire logic        vaddrValid,
  input  wire logic        wide_kernel_addr_enable,
  input  wire logic [7:0]  addr_space_tag,
  input  wire logic [2:0]  pageAttr,
  input  wire logic        instrRetired,
  input  wire logic        tlbOpValid,
  input  wire ksd_op_t     tlbOp,
  input  wire logic        tlbProbeHit,
  input  wire logic [4:0]  tlbProbeIndex,
  input  wire logic [31:0] tlbReadEven,
  input  wire logic [31:0] tlbReadOdd,
  input  wire logic [31:0] tlbReadMask,
  output logic             segMapped,
  output logic             segCached,
  output logic             segAddrError,
  output ksd_seg_t         segKind,
  output logic      [31:0] physAddr,
  output logic      [71:0] taggedVaddr,
  output logic      [4:0]  tlbEntrySel,
  output logic             tlbWriteEn,
  output logic      [31:0] tlbWriteEven,
  output logic      [31:0] tlbWriteOdd,
  output logic      [7:0]  tlbCompareMask
);

  ////////////////////////////////////////////////////////////////////////
  // Registers
  logic        probeFail_reg;
  logic [4:0]  entryIdx_reg;
  logic [4:0]  replace_reg;
  logic [4:0]  wired_reg;
  logic [31:0] lowEven_reg;
  logic [31:0] lowOdd_reg;
  logic [7:0]  page_size_compare_mask_reg;
  logic [2:0]  lowmem_cache_policy_reg;
  logic        wrPend_reg;
  logic [2:0]  wrIdx_reg;

  ////////////////////////////////////////////////////////////////////////
  // Bus decode
  wire         addrPhase  = hsel & hready & htrans[1];
  wire         busWrite   = wrPend_reg;
  wire [2:0]   rdIdx      = haddr[4:2];
  wire         wrEntry    = busWrite & (wrIdx_reg == IDX_ENTRY_PTR);
  wire         wrEven     = busWrite & (wrIdx_reg == IDX_LOW_EVEN);
  wire         wrOdd      = busWrite & (wrIdx_reg == IDX_LOW_ODD);
  wire         wrMask     = busWrite & (wrIdx_reg == IDX_PAGE_MASK);
  wire         wrWired    = busWrite & (wrIdx_reg == IDX_WIRED);
  wire         wrCtrl     = busWrite & (wrIdx_reg == IDX_CONTROL);

  wire         opProbe    = tlbOpValid & (tlbOp == KSD_OP_PROBE);
  wire         opRead     = tlbOpValid & (tlbOp == KSD_OP_READ);
  wire         opWriteRnd = tlbOpValid & (tlbOp == KSD_OP_WRITE_RND);
  wire         opWriteIdx = tlbOpValid & (tlbOp == KSD_OP_WRITE_IDX);

  wire [31:0]  entryRead  = {probeFail_reg, 26'h0, entryIdx_reg};
  wire [31:0]  replRead   = {27'h0, replace_reg};
  wire [31:0]  maskRead   = {13'h0, page_size_compare_mask_reg, 11'h0};
  wire [31:0]  rdMux =
    (rdIdx == IDX_ENTRY_PTR) ? entryRead :
    (rdIdx == IDX_REPLACE)   ? replRead :
    (rdIdx == IDX_LOW_EVEN)  ? lowEven_reg :
    (rdIdx == IDX_LOW_ODD)   ? lowOdd_reg :
    (rdIdx == IDX_PAGE_MASK) ? maskRead :
    (rdIdx == IDX_WIRED)     ? {27'h0, wired_reg} :
    (rdIdx == IDX_CONTROL)   ? {29'h0, lowmem_cache_policy_reg} :
    32'h0;
  wire         mapped     = (haddr[7:5] == 3'h0) & (rdIdx != 3'h4);

  ////////////////////////////////////////////////////////////////////////
  // Replacement pointer
  wire         atFloor    = (replace_reg <= wired_reg);
  wire [4:0]   replDec    = atFloor ? REPLACE_TOP : replace_reg - 5'h1;
  wire [4:0]   replace_next =
    wrWired ? REPLACE_TOP :
    instrRetired ? replDec :
    replace_reg;

  ////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: zero wait states, always OKAY
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wrPend_reg <= 1'b0;
      wrIdx_reg  <= 3'h0;
      hrdata     <= 32'h0;
    end else begin
      wrPend_reg <= addrPhase & hwrite & mapped;
      wrIdx_reg  <= rdIdx;
      if (addrPhase & ~hwrite) begin
        hrdata <= mapped ? rdMux : 32'h0;
      end
    end
  end
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  ////////////////////////////////////////////////////////////////////////
  // Software registers and TLB op capture
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wired_reg               <= WIRED_RESET;
      replace_reg             <= REPLACE_TOP;
      probeFail_reg           <= 1'b0;
      entryIdx_reg            <= 5'h0;
      lowEven_reg             <= 32'h0;
      lowOdd_reg              <= 32'h0;
      page_size_compare_mask_reg            <= 8'h0;
      lowmem_cache_policy_reg <= 3'h0;
    end else begin
      replace_reg <= replace_next;
      if (wrWired) begin
        wired_reg <= hwdata[4:0];
      end
      if (wrCtrl) begin
        lowmem_cache_policy_reg <= hwdata[2:0];
      end
      if (opProbe) begin
        probeFail_reg <= ~tlbProbeHit;
        if (tlbProbeHit) begin
          entryIdx_reg <= tlbProbeIndex;
        end
      end else if (wrEntry) begin
        probeFail_reg <= hwdata[PROBE_BIT];
        entryIdx_reg  <= hwdata[4:0];
      end
      if (opRead) begin
        lowEven_reg  <= tlbReadEven;
        lowOdd_reg   <= tlbReadOdd;
        page_size_compare_mask_reg <= tlbReadMask[MASK_HI:MASK_LO];
      end else begin
        if (wrEven) begin
          lowEven_reg <= hwdata;
        end
        if (wrOdd) begin
          lowOdd_reg <= hwdata;
        end
        if (wrMask) begin
          page_size_compare_mask_reg <= hwdata[MASK_HI:MASK_LO];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // TLB write port
  assign tlbEntrySel    = opWriteRnd ? replace_reg : entryIdx_reg;
  assign tlbWriteEn     = opWriteRnd | opWriteIdx;
  assign tlbWriteEven   = lowEven_reg;
  assign tlbWriteOdd    = lowOdd_reg;
  assign tlbCompareMask = page_size_compare_mask_reg;

  ////////////////////////////////////////////////////////////////////////
  // Kernel address decode
  wire         isKernTop  = wide_kernel_addr_enable &
                            (vaddr[63:62] == TOP_KERNEL);
  wire         isCompat   = isKernTop & (&vaddr[61:31]);
  wire         isPhys     = wide_kernel_addr_enable &
                            (vaddr[63:62] == TOP_PHYS);
  wire         physBad    = |vaddr[58:32];
  wire         physCached = (vaddr[61:59] != UNCACHED_CODE);
  wire         pageCached = (pageAttr != UNCACHED_CODE);
  wire         lowCached  = (lowmem_cache_policy_reg != UNCACHED_CODE);
  wire [1:0]   compatSel  = vaddr[30:29];
  wire [31:0]  lowAddr    = vaddr[31:0];

  ksd_seg_t    segKindNext;
  logic        mappedNext;
  logic        cachedNext;
  logic [31:0] physNext;
  always_comb begin
    segKindNext = KSD_SEG_NONE;
    mappedNext  = 1'b0;
    cachedNext  = 1'b0;
    physNext    = 32'h0;
    if (isCompat) begin
      unique case (compatSel)
        2'h0: begin
          segKindNext = KSD_SEG_COMPAT0;
          cachedNext  = lowCached;
          physNext    = lowAddr - LOW_KERNEL_BASE;
        end
        2'h1: begin
          segKindNext = KSD_SEG_COMPAT1;
          physNext    = lowAddr - UPPER_KERNEL_BASE;
        end
        2'h2: begin
          segKindNext = KSD_SEG_COMPATS;
          mappedNext  = 1'b1;
          cachedNext  = pageCached;
        end
        2'h3: begin
          segKindNext = KSD_SEG_COMPAT3;
          mappedNext  = 1'b1;
          cachedNext  = pageCached;
        end
      endcase
    end else if (isKernTop) begin
      segKindNext = KSD_SEG_KMAPPED;
      mappedNext  = 1'b1;
      cachedNext  = pageCached;
    end else if (isPhys & ~physBad) begin
      segKindNext = KSD_SEG_PHYS;
      cachedNext  = physCached;
      physNext    = lowAddr;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      segKind      <= KSD_SEG_NONE;
      segMapped    <= 1'b0;
      segCached    <= 1'b0;
      segAddrError <= 1'b0;
      physAddr     <= 32'h0;
      taggedVaddr  <= 72'h0;
    end else if (vaddrValid) begin
      segKind      <= segKindNext;
      segMapped    <= mappedNext;
      segCached    <= cachedNext;
      segAddrError <= isPhys & physBad;
      physAddr     <= physNext;
      taggedVaddr  <= {addr_space_tag, vaddr};
    end
  end

endmodule : ksd_kernel_seg

// ---- sim/ksd_kernel_seg_properties.sv ----
/*
  Checker on the decode and TLB op outputs of ksd_kernel_seg.
  Assumes it is bound to the design ports, one clock, async reset.
*/
`timescale 1ns/10ps
module ksd_kernel_seg_properties
  import ksd_pkg::*;
(
  input wire logic        clk,
  input wire logic        arst_n,
  input wire logic [63:0] vaddr,
  input wire logic        vaddrValid,
  input wire logic        wide_kernel_addr_enable,
  input wire logic [7:0]  addr_space_tag,
  input wire logic [2:0]  pageAttr,
  input wire logic        tlbOpValid,
  input wire ksd_op_t     tlbOp,
  input wire logic        segMapped,
  input wire logic        segCached,
  input wire ksd_seg_t    segKind,
  input wire logic [31:0] physAddr,
  input wire logic [71:0] taggedVaddr,
  input wire logic        tlbWriteEn
);
  wire        kx     = vaddrValid && wide_kernel_addr_enable;
  wire        top3   = kx && vaddr[63:62] == TOP_KERNEL;
  wire        kmap   = top3 && vaddr[61:40] == 22'h0;
  wire        compat = top3 && &vaddr[61:31];
  wire [1:0]  cSel   = vaddr[30:29];
  wire [2:0]  pSel   = vaddr[61:59];
  wire [3:0]  cKind  = {2'h0, cSel} + 4'h3;
  wire [31:0] lowV   = vaddr[31:0] - LOW_KERNEL_BASE;
  wire        attrOk = pageAttr != UNCACHED_CODE;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  phys_cache_a: assert property (
    kx && vaddr[63:62] == TOP_PHYS && vaddr[58:32] == 27'h0
    |=> !segMapped && segCached == ($past(pSel) != 3'h2))
    else $error("phys window cacheability wrong");
  kmapped_a: assert property (
    kmap |=> segKind == KSD_SEG_KMAPPED && segMapped
    && segCached == $past(attrOk)) else $error("mapped kernel decode wrong");
  tag_ext_a: assert property (
    kmap |=> taggedVaddr == {$past(addr_space_tag), $past(vaddr)})
    else $error("tagged address wrong");
  compat_sel_a: assert property (
    compat |=> segKind == $past(cKind)) else $error("compat select wrong");
  compat_first_a: assert property (
    compat && cSel == 2'h0 |=> !segMapped && physAddr == $past(lowV))
    else $error("first compat space address wrong");
  compat_second_a: assert property (
    compat && cSel == 2'h1 |=> !segMapped && !segCached)
    else $error("second compat space not uncached");
  compat_mapped_a: assert property (
    compat && cSel[1] |=> segMapped && segCached == $past(attrOk))
    else $error("mapped compat space caching wrong");
  write_en_a: assert property (
    tlbOpValid |-> tlbWriteEn == tlbOp[1]) else $error("write enable wrong");
endmodule : ksd_kernel_seg_properties

bind ksd_kernel_seg ksd_kernel_seg_properties u_props (.clk, .arst_n,
  .vaddr, .vaddrValid, .wide_kernel_addr_enable, .addr_space_tag,
  .pageAttr, .tlbOpValid, .tlbOp, .segMapped, .segCached, .segKind,
  .physAddr, .taggedVaddr, .tlbWriteEn);

// ---- sim/ksd_pipe_model.sv ----
/*
  Translation array model answering TLB ops of the pipeline side.
  Assumes answers are read in the op cycle; probe hits the last write unless probeMiss is set.
*/
`timescale 1ns/10ps
module ksd_pipe_model
  import ksd_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        probeMiss,
  input  wire logic        tlbOpValid,
  input  wire logic [4:0]  tlbEntrySel,
  input  wire logic        tlbWriteEn,
  input  wire logic [31:0] tlbWriteEven,
  input  wire logic [31:0] tlbWriteOdd,
  input  wire logic [7:0]  tlbCompareMask,
  output logic             tlbProbeHit,
  output logic      [4:0]  tlbProbeIndex,
  output logic      [31:0] tlbReadEven,
  output logic      [31:0] tlbReadOdd,
  output logic      [31:0] tlbReadMask
);
  logic [31:0] ev [32];
  logic [31:0] od [32];
  logic [7:0]  mk [32];
  logic [4:0]  last;
  wire         a = tlbOpValid;
  always @(posedge clk) if (tlbWriteEn) begin
    ev[tlbEntrySel] <= tlbWriteEven;
    od[tlbEntrySel] <= tlbWriteOdd;
    mk[tlbEntrySel] <= tlbCompareMask;
    last <= tlbEntrySel;
  end
  // Outside ops the answers are inverted and the read mask zeroed so stale values never match
  assign tlbProbeHit   = a ? !probeMiss : probeMiss;
  assign tlbProbeIndex = a ? last : ~last;
  assign tlbReadEven   = a ? ev[tlbEntrySel] : ~ev[tlbEntrySel];
  assign tlbReadOdd    = a ? od[tlbEntrySel] : ~od[tlbEntrySel];
  assign tlbReadMask   = {13'h0, a ? mk[tlbEntrySel] : 8'h0, 11'h0};
endmodule : ksd_pipe_model

// ---- sim/ksd_kernel_seg_test.sv ----
/*
  Bench for ksd_kernel_seg: AHB-Lite register tasks, TLB ops, decode.
  Assumes the pipe model on the TLB side and a zero wait slave.
*/
`timescale 1ns/10ps
module ksd_kernel_seg_test
  import ksd_pkg::*;
;
  logic        clk, arst_n, hwrite, vaddrValid, kx, instrRetired;
  logic        tlbOpValid, probeMiss, tlbProbeHit, tlbWriteEn, hreadyout;
  logic [1:0]  htrans;
  logic [2:0]  pageAttr;
  logic [4:0]  tlbProbeIndex, tlbEntrySel;
  logic [7:0]  tlbCompareMask;
  logic [31:0] haddr, hwdata, hrdata, r, tlbWriteEven, tlbWriteOdd;
  logic [31:0] tlbReadEven, tlbReadOdd, tlbReadMask;
  logic [63:0] vaddr;
  ksd_op_t     tlbOp;
  ksd_seg_t    segKind;
  logic        segCached;
  int          err_count, n_compared;
  ksd_kernel_seg dut (.clk, .arst_n, .hsel(1'b1), .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
    .hresp(), .vaddr, .vaddrValid, .wide_kernel_addr_enable(kx),
    .addr_space_tag(8'h5A), .pageAttr, .instrRetired, .tlbOpValid, .tlbOp,
    .tlbProbeHit, .tlbProbeIndex, .tlbReadEven, .tlbReadOdd, .tlbReadMask,
    .segMapped(), .segCached, .segAddrError(), .segKind, .physAddr(),
    .taggedVaddr(), .tlbEntrySel, .tlbWriteEn, .tlbWriteEven, .tlbWriteOdd,
    .tlbCompareMask);
  ksd_pipe_model u_pipe (.clk, .probeMiss, .tlbOpValid, .tlbEntrySel,
    .tlbWriteEn, .tlbWriteEven, .tlbWriteOdd, .tlbCompareMask, .tlbProbeHit,
    .tlbProbeIndex, .tlbReadEven, .tlbReadOdd, .tlbReadMask);
  task automatic complete_run;
    if (err_count == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] g, e);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("unexpected t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [31:0] a, d);
    int n;
    n = 0;
    haddr <= a; hwrite <= w; htrans <= 2'h2;
    do begin @(posedge clk); n++; end while (hreadyout !== 1'b1 && n < 50);
    htrans <= 2'h0; hwdata <= d;
    do begin @(posedge clk); n++; end while (hreadyout !== 1'b1 && n < 50);
    r = hrdata;
    if (n >= 50) begin err_count++; complete_run(); end
  endtask : bus
  task automatic wr(input logic [31:0] a, d); bus(1'b1, a, d); endtask : wr
  task automatic rd(input logic [31:0] a, e);
    bus(1'b0, a, 32'h0);
    chk(r, e);
  endtask : rd
  task automatic op(input ksd_op_t o, input logic [4:0] s);
    tlbOp <= o; tlbOpValid <= 1'b1;
    #1 if (o != KSD_OP_PROBE) chk({27'h0, tlbEntrySel}, {27'h0, s});
    chk({31'h0, tlbWriteEn}, {31'h0, o[1]});
    @(posedge clk); tlbOpValid <= 1'b0;
    @(posedge clk);
  endtask : op
  task automatic dec(input logic [63:0] v, input logic [3:0] k, input c);
    vaddr <= v; vaddrValid <= 1'b1;
    @(posedge clk); vaddrValid <= 1'b0;
    @(posedge clk);
    chk({28'h0, segKind}, {28'h0, k});
    chk({31'h0, segCached}, {31'h0, c});
  endtask : dec
  task automatic ret(input int n);
    repeat (n) begin instrRetired <= 1'b1; @(posedge clk); end
    instrRetired <= 1'b0;
  endtask : ret
  initial begin clk = 1'b0; forever #2 clk = ~clk; end
  initial begin
    {arst_n, hwrite, vaddrValid, instrRetired, tlbOpValid, probeMiss} = '0;
    {htrans, haddr, hwdata, vaddr} = '0;
    kx = 1'b1; pageAttr = 3'h3; tlbOp = KSD_OP_PROBE;
    err_count = 0; n_compared = 0;
    repeat (16) @(posedge clk); arst_n <= 1'b1;
    rd(32'h04, 32'h1F);
    wr(32'h04, 32'h0); rd(32'h04, 32'h1F);
    wr(32'h00, 32'h7E5); rd(32'h00, 32'h05);
    wr(32'h14, 32'h7F800); rd(32'h14, 32'h7F800);
    chk({24'h0, tlbCompareMask}, 32'hFF);
    wr(32'h08, 32'h1234_5678); wr(32'h0C, 32'h0ABC_DEF0);
    rd(32'h10, 32'h0);
    op(KSD_OP_WRITE_RND, 5'h1F);
    op(KSD_OP_WRITE_IDX, 5'h05);
    chk(tlbWriteOdd, 32'h0ABC_DEF0);
    probeMiss <= 1'b1; op(KSD_OP_PROBE, 5'h0);
    rd(32'h00, 32'h8000_0005);
    probeMiss <= 1'b0; wr(32'h00, 32'h0); op(KSD_OP_PROBE, 5'h0);
    rd(32'h00, 32'h05);
    wr(32'h08, 32'h0); wr(32'h14, 32'h0); op(KSD_OP_READ, 5'h05);
    rd(32'h08, 32'h1234_5678); rd(32'h14, 32'h7F800);
    ret(3); wr(32'h18, 32'h4); rd(32'h04, 32'h1F);
    ret(27); rd(32'h04, 32'h04);
    ret(1); rd(32'h04, 32'h1F);
    dec(64'h9000_0000_0000_1000, KSD_SEG_PHYS, 1'b0);
    dec(64'hB800_0000_0000_1000, KSD_SEG_PHYS, 1'b1);
    dec(64'h8800_0000_0000_1000, KSD_SEG_PHYS, 1'b1);
    dec(64'h8000_0001_0000_0000, KSD_SEG_NONE, 1'b0);
    dec(64'hC000_0000_0000_2000, KSD_SEG_KMAPPED, 1'b1);
    for (int p = 2; p < 4; p++) begin
      pageAttr <= p[2:0]; wr(32'h1C, p);
      for (int i = 0; i < 4; i++)
        dec({33'h1_FFFF_FFFF, i[1:0], 29'h0}, 4'h3 + i[3:0],
            p == 3 && i != 1);
    end
    complete_run();
  end
endmodule : ksd_kernel_seg_test
